/* common/tms_pkg.sv */
// shared constants and types of the temperature monitor status logic
package tms_pkg;
    typedef logic [7:0] tms_temp_t;
    // register pointers
    localparam logic [7:0] PTR_STATUS_RD = 8'h02;
    localparam logic [7:0] PTR_CFG_RD = 8'h03;
    localparam logic [7:0] PTR_CFG_WR = 8'h09;
    localparam logic [7:0] PTR_ONESHOT_WR = 8'h0F;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_DATA = 8'hFF;
    // status fields
    localparam int STS_BUSY = 7;
    localparam int STS_LIM_LSB = 3;
    localparam int STS_OPEN = 2;
    localparam int STS_ROVER = 1;
    localparam int STS_LOVER = 0;
    // limit flag vector order {local high, local low, remote high, remote low}
    localparam int LIM_LH = 3;
    localparam int LIM_LL = 2;
    localparam int LIM_RH = 1;
    localparam int LIM_RL = 0;
    // configuration fields
    localparam int CFG_MASK = 7;
    localparam int CFG_SD = 6;
    localparam int CFG_SHARED = 5;
    localparam int CFG_RANGE = 2;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] CFG_WMASK = 8'hE4;
    // smbus alert response address
    localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    typedef enum logic [2:0] {
        SL_IDLE = 3'b000,
        SL_ADDR = 3'b001,
        SL_AACK = 3'b010,
        SL_WR = 3'b011,
        SL_WACK = 3'b100,
        SL_RD = 3'b101,
        SL_RACK = 3'b110
    } tms_sl_state_t;
    typedef enum logic [0:0] {
        CV_IDLE = 1'b0,
        CV_BUSY = 1'b1
    } tms_cv_state_t;
endpackage

/* common/tms_bus_if.sv */
// strobes between serial slave engine and register logic
`timescale 1ns/1ps
interface tms_bus_if;
    logic wrStb;
    logic wrFirst;
    logic [7:0] wrData;
    logic [7:0] rdData;
    logic rdDone;
    logic araDone;
    logic alertPending;
    modport slv (output wrStb, wrFirst, wrData, rdDone, araDone, input rdData, alertPending);
    modport regs (input wrStb, wrFirst, wrData, rdDone, araDone, output rdData, alertPending);
endinterface

/* design/tms_serial_slave.sv */
// two-wire serial slave engine: pointer and data strobes, read bytes, alert response
`timescale 1ns/1ps
module tms_serial_slave #(
    parameter logic [6:0] DEV_ADDR = 7'h48
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    tms_bus_if.slv bus
);
    import tms_pkg::*;

    logic sclS1_q, sclS2_q, sclS3_q, sdaS1_q, sdaS2_q, sdaS3_q;
    logic startSeen, stopSeen, sclRise, sclFall, goRead;
    tms_sl_state_t state_q;
    logic [3:0] cnt_q;
    logic [7:0] sr_q, tx_q, txByte;
    logic rw_q, ara_q, first_q, nack_q, sdaOe_q, sdaOut_q;

    // pins sampled twice; edges only from the second and third stages
    always_ff @(posedge clock) begin
        if (!nrst) begin
            {sclS1_q, sclS2_q, sclS3_q} <= 3'h7;
            {sdaS1_q, sdaS2_q, sdaS3_q} <= 3'h7;
        end else begin
            sclS1_q <= sclIn;
            sclS2_q <= sclS1_q;
            sclS3_q <= sclS2_q;
            sdaS1_q <= sdaIn;
            sdaS2_q <= sdaS1_q;
            sdaS3_q <= sdaS2_q;
        end
    end

    assign startSeen = sclS2_q & sdaS3_q & ~sdaS2_q;
    assign stopSeen = sclS2_q & ~sdaS3_q & sdaS2_q;
    assign sclRise = sclS2_q & ~sclS3_q;
    assign sclFall = ~sclS2_q & sclS3_q;
    assign txByte = ara_q ? {DEV_ADDR, 1'b0} : bus.rdData;
    assign goRead = (state_q == SL_RACK) ? ~nack_q : rw_q;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            state_q <= SL_IDLE;
            cnt_q <= 4'h0;
            sr_q <= 8'h00;
            tx_q <= 8'hFF;
            rw_q <= 1'b0;
            ara_q <= 1'b0;
            first_q <= 1'b0;
            nack_q <= 1'b1;
            sdaOe_q <= 1'b0;
            sdaOut_q <= 1'b0;
            bus.wrStb <= 1'b0;
            bus.wrFirst <= 1'b0;
            bus.wrData <= 8'h00;
            bus.rdDone <= 1'b0;
            bus.araDone <= 1'b0;
        end else begin
            bus.wrStb <= 1'b0;
            bus.rdDone <= 1'b0;
            bus.araDone <= 1'b0;
            if (sclRise && (state_q == SL_ADDR || state_q == SL_WR || state_q == SL_RD)) begin
                sr_q <= {sr_q[6:0], sdaS2_q};
                cnt_q <= cnt_q + 4'h1;
            end
            if (sclRise && state_q == SL_RACK) begin
                nack_q <= sdaS2_q;
            end
            if (startSeen) begin
                state_q <= SL_ADDR;
                cnt_q <= 4'h0;
                first_q <= 1'b1;
                sdaOe_q <= 1'b0;
            end else if (stopSeen) begin
                state_q <= SL_IDLE;
                sdaOe_q <= 1'b0;
            end else if (sclFall) begin
                case (state_q)
                    SL_ADDR: begin
                        if (cnt_q == BITS_PER_BYTE) begin
                            // alert response is answered only while an alert is pending
                            if (sr_q[7:1] == DEV_ADDR || (sr_q[7:1] == ALERT_RESP_ADDR
                                    && sr_q[0] && bus.alertPending)) begin
                                sdaOe_q <= 1'b1;
                                rw_q <= sr_q[0];
                                ara_q <= (sr_q[7:1] != DEV_ADDR);
                                state_q <= SL_AACK;
                            end else begin
                                state_q <= SL_IDLE;
                            end
                        end
                    end
                    SL_AACK, SL_WACK, SL_RACK: begin
                        cnt_q <= 4'h0;
                        if (goRead) begin
                            sdaOe_q <= ~txByte[7];
                            tx_q <= {txByte[6:0], 1'b1};
                            state_q <= SL_RD;
                        end else begin
                            sdaOe_q <= 1'b0;
                            state_q <= (state_q == SL_RACK) ? SL_IDLE : SL_WR;
                        end
                    end
                    SL_WR: begin
                        if (cnt_q == BITS_PER_BYTE) begin
                            bus.wrStb <= 1'b1;
                            bus.wrFirst <= first_q;
                            bus.wrData <= sr_q;
                            first_q <= 1'b0;
                            sdaOe_q <= 1'b1;
                            state_q <= SL_WACK;
                        end
                    end
                    SL_RD: begin
                        if (cnt_q == BITS_PER_BYTE) begin
                            sdaOe_q <= 1'b0;
                            state_q <= SL_RACK;
                            bus.araDone <= ara_q;
                            bus.rdDone <= ~ara_q;
                        end else begin
                            sdaOe_q <= ~tx_q[7];
                            tx_q <= {tx_q[6:0], 1'b1};
                        end
                    end
                    default: begin
                        state_q <= state_q;
                    end
                endcase
            end
        end
    end

    assign sdaOe = sdaOe_q;
    assign sdaOut = sdaOut_q;
endmodule // tms_serial_slave

/* design/tms_status_top.sv */
// temperature monitor status flags, configuration, conversion control and alarm outputs
// Operation
// - status bit 7 is one while a conversion runs, zero when idle
// - status bit 6 sets when local temperature exceeds local high limit
// - status bit 5 sets when local temperature falls below local low limit
// - status bit 4 sets when remote temperature exceeds remote high limit
// - status bit 3 sets when remote temperature falls below remote low limit
// - status bit 2 sets on open remote junction, stays set after reconnection until a status read
// - status is read-only at pointer 02h; writes do nothing
// - status read clears limit and open flags whose cause has gone
// - interrupt mode: any of five flags sets latch driving shared output low
// - latch released only by address read with flags and causes clear, or by leaving interrupt mode
// - bits 1 and 0 follow remote and local over-limit, clearing themselves
// - overheat output low while either channel over limit, else high
// - over-limit releases only at or below threshold minus hysteresis
// - second over-limit mode: shared output follows high limits only
// - interrupt mode latches five flags; other mode latches only open flag
// - configuration bit 7 masks interrupt output, ignored in second mode
// - bit 6 zero converts continuously; one finishes conversion then shuts down
// - one-shot write in shutdown runs exactly one conversion
// - configuration bit 5 selects interrupt or second over-limit mode
// - configuration bit 2 selects standard or extended range format
// - configuration read at 03h, written at 09h, resets to 00h
// - one-shot register is write-only at 0Fh, any value starts
`timescale 1ns/1ps
module tms_status_top #(
    parameter logic [6:0] DEV_ADDR = 7'h48
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic rateTick,
    input wire logic convDone,
    input wire tms_pkg::tms_temp_t localTemp,
    input wire tms_pkg::tms_temp_t remoteTemp,
    input wire tms_pkg::tms_temp_t localHighLim,
    input wire tms_pkg::tms_temp_t localLowLim,
    input wire tms_pkg::tms_temp_t remoteHighLim,
    input wire tms_pkg::tms_temp_t remoteLowLim,
    input wire tms_pkg::tms_temp_t localOverLim,
    input wire tms_pkg::tms_temp_t remoteOverLim,
    input wire tms_pkg::tms_temp_t overHyst,
    input wire logic remoteOpen,
    output logic convStart,
    output logic rangeExt,
    output logic overheatOutN,
    output logic overheatOe,
    output logic sharedOutN,
    output logic sharedOe
);
    import tms_pkg::*;

    tms_bus_if bus ();

    tms_serial_slave #(
        .DEV_ADDR(DEV_ADDR)
    ) uSlave (
        .clock(clock),
        .nrst(nrst),
        .sclIn(sclIn),
        .sdaIn(sdaIn),
        .sdaOut(sdaOut),
        .sdaOe(sdaOe),
        .bus(bus)
    );

    logic [7:0] ptr_q, cfg_q, statusVal;
    logic [3:0] cond_q, limFlags_q, condNow;
    logic openFlag_q, lOver_q, rOver_q, alertLatch_q, oneShot_q, convStart_q;
    logic rangeExt_q, overheatOutN_q, overheatOe_q, sharedOutN_q, sharedOe_q;
    logic statusRd, cfgWr, oneShotWr, alertMode, anyFlag, anyCond, sharedLow;
    tms_cv_state_t cvState_q;

    // over-limit with hysteresis; a threshold below zero never releases
    function automatic logic overNext(logic cur, tms_temp_t t, tms_temp_t lim,
            tms_temp_t hyst);
        logic [8:0] rel;
        rel = {1'b0, lim} - {1'b0, hyst};
        if (cur) begin
            overNext = rel[8] | ({1'b0, t} > rel);
        end else begin
            overNext = (t > lim);
        end
    endfunction

    assign condNow = {localTemp > localHighLim, localTemp < localLowLim,
        remoteTemp > remoteHighLim, remoteTemp < remoteLowLim};
    // status clears on the done pulse, after the byte was already shifted out
    assign statusRd = bus.rdDone & (ptr_q == PTR_STATUS_RD);
    // only the configuration and one-shot pointers accept data; status ignores writes
    assign cfgWr = bus.wrStb & ~bus.wrFirst & (ptr_q == PTR_CFG_WR);
    assign oneShotWr = bus.wrStb & ~bus.wrFirst & (ptr_q == PTR_ONESHOT_WR);
    assign alertMode = ~cfg_q[CFG_SHARED];
    assign anyFlag = (|limFlags_q) | openFlag_q;
    assign anyCond = (|cond_q) | remoteOpen;
    assign bus.alertPending = alertLatch_q & ~cfg_q[CFG_MASK];

    always_ff @(posedge clock) begin
        if (!nrst) begin
            ptr_q <= PTR_RESET;
        end else if (bus.wrStb && bus.wrFirst) begin
            ptr_q <= bus.wrData;
        end
    end

    // reserved bits are not stored and read back as zero
    always_ff @(posedge clock) begin
        if (!nrst) begin
            cfg_q <= CFG_RESET;
        end else if (cfgWr) begin
            cfg_q <= bus.wrData & CFG_WMASK;
        end
    end

    assign statusVal = {cvState_q == CV_BUSY, limFlags_q, openFlag_q, rOver_q, lOver_q};

    always_comb begin
        case (ptr_q)
            PTR_STATUS_RD: bus.rdData = statusVal;
            PTR_CFG_RD: bus.rdData = cfg_q;
            default: bus.rdData = UNMAPPED_DATA;
        endcase
    end

    // comparator causes refresh once per finished conversion
    always_ff @(posedge clock) begin
        if (!nrst) begin
            cond_q <= 4'h0;
            lOver_q <= 1'b0;
            rOver_q <= 1'b0;
        end else if (convDone) begin
            cond_q <= condNow;
            lOver_q <= overNext(lOver_q, localTemp, localOverLim, overHyst);
            rOver_q <= overNext(rOver_q, remoteTemp, remoteOverLim, overHyst);
        end
    end

    // a cause present in the clearing cycle keeps its flag set
    always_ff @(posedge clock) begin
        if (!nrst) begin
            limFlags_q <= 4'h0;
        end else if (!alertMode) begin
            limFlags_q <= cond_q;
        end else begin
            limFlags_q <= cond_q | (limFlags_q & ~{4{statusRd}});
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            openFlag_q <= 1'b0;
        end else begin
            openFlag_q <= remoteOpen | (openFlag_q & ~statusRd);
        end
    end

    // latch ignores status reads; only the alert response read or leaving interrupt mode may release it
    always_ff @(posedge clock) begin
        if (!nrst) begin
            alertLatch_q <= 1'b0;
        end else if (!alertMode) begin
            alertLatch_q <= 1'b0;
        end else if (anyFlag) begin
            alertLatch_q <= 1'b1;
        end else if (bus.araDone && !anyCond) begin
            alertLatch_q <= 1'b0;
        end
    end

    assign sharedLow = alertMode ? (alertLatch_q & ~cfg_q[CFG_MASK])
        : (limFlags_q[LIM_LH] | limFlags_q[LIM_RH]);

    always_ff @(posedge clock) begin
        if (!nrst) begin
            sharedOutN_q <= 1'b1;
            sharedOe_q <= 1'b0;
            overheatOutN_q <= 1'b1;
            overheatOe_q <= 1'b0;
            rangeExt_q <= 1'b0;
        end else begin
            sharedOutN_q <= ~sharedLow;
            sharedOe_q <= sharedLow;
            overheatOutN_q <= ~(lOver_q | rOver_q);
            overheatOe_q <= lOver_q | rOver_q;
            rangeExt_q <= cfg_q[CFG_RANGE];
        end
    end

    // one-shot request is kept until the engine is free to start it
    always_ff @(posedge clock) begin
        if (!nrst) begin
            oneShot_q <= 1'b0;
        end else if (oneShotWr && cfg_q[CFG_SD]) begin
            oneShot_q <= 1'b1;
        end else if (convStart_q) begin
            oneShot_q <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            cvState_q <= CV_IDLE;
            convStart_q <= 1'b0;
        end else begin
            convStart_q <= 1'b0;
            case (cvState_q)
                CV_IDLE: begin
                    if ((!cfg_q[CFG_SD] && rateTick) || (oneShot_q && !convStart_q)) begin
                        cvState_q <= CV_BUSY;
                        convStart_q <= 1'b1;
                    end
                end
                CV_BUSY: begin
                    // shutdown never aborts; the running conversion finishes first
                    if (convDone) begin
                        cvState_q <= CV_IDLE;
                    end
                end
                default: begin
                    cvState_q <= CV_IDLE;
                end
            endcase
        end
    end

    assign convStart = convStart_q;
    assign rangeExt = rangeExt_q;
    assign overheatOutN = overheatOutN_q;
    assign overheatOe = overheatOe_q;
    assign sharedOutN = sharedOutN_q;
    assign sharedOe = sharedOe_q;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    property p_busy;
        convStart_q |-> statusVal[STS_BUSY] ##1 (statusVal[STS_BUSY] || convDone);
    endproperty
    a_busy: assert property (p_busy) else $error("busy bit not set by conversion");

    property p_lim_set;
        (cond_q != 4'h0 && !convDone && alertMode && !bus.wrStb)
            |=> ((limFlags_q & $past(cond_q)) == $past(cond_q));
    endproperty
    a_lim_set: assert property (p_lim_set) else $error("limit flag missed");

    property p_open_set;
        remoteOpen |=> openFlag_q ##0 statusVal[STS_OPEN];
    endproperty
    a_open_set: assert property (p_open_set) else $error("open flag missed");

    property p_read_clear;
        (statusRd && !remoteOpen) |=> !openFlag_q;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("open flag not cleared");

    property p_hold;
        (!statusRd && alertMode && !bus.wrStb && !convDone)
            |=> ((limFlags_q & $past(limFlags_q)) == $past(limFlags_q));
    endproperty
    a_hold: assert property (p_hold) else $error("latched flag lost");

    property p_latch_hold;
        (alertMode && anyFlag && !bus.wrStb) |=> alertLatch_q [*2];
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch released early");

    property p_overheat;
        (lOver_q || rOver_q) |=> (!overheatOutN && overheatOe);
    endproperty
    a_overheat: assert property (p_overheat) else $error("overheat output not low");

    property p_hyst;
        (convDone && lOver_q && localOverLim >= overHyst
            && localTemp > (localOverLim - overHyst)) |=> lOver_q;
    endproperty
    a_hyst: assert property (p_hyst) else $error("over flag released inside band");

    property p_mask;
        (cfg_q[CFG_MASK] && alertMode && !bus.wrStb) |=> sharedOutN;
    endproperty
    a_mask: assert property (p_mask) else $error("masked output driven low");

    property p_cfg_wr;
        cfgWr |=> (cfg_q == ($past(bus.wrData) & CFG_WMASK));
    endproperty
    a_cfg_wr: assert property (p_cfg_wr) else $error("configuration write lost");

    property p_status_ro;
        (bus.wrStb && !bus.wrFirst && ptr_q == PTR_STATUS_RD) |=> $stable(cfg_q);
    endproperty
    a_status_ro: assert property (p_status_ro) else $error("status write had effect");

    property p_shared_high;
        (!alertMode && !limFlags_q[LIM_LH] && !limFlags_q[LIM_RH]) |=> sharedOutN;
    endproperty
    a_shared_high: assert property (p_shared_high) else $error("second output low");

    property p_sd_no_start;
        (cfg_q[CFG_SD] && !oneShot_q) |=> !convStart_q;
    endproperty
    a_sd_no_start: assert property (p_sd_no_start) else $error("start in shutdown");

    property p_no_abort;
        (cvState_q == CV_BUSY && !convDone) |=> (cvState_q == CV_BUSY);
    endproperty
    a_no_abort: assert property (p_no_abort) else $error("conversion aborted");
endmodule // tms_status_top

/* tb/tms_host_model.sv */
// behavioural two-wire bus host that drives the monitor's serial pins
`timescale 1ns/1ps
module tms_host_model #(
    parameter logic [6:0] DEV_ADDR = 7'h48
) (
    input wire logic clock,
    input wire logic sdaOe,
    output logic sclIn,
    output logic sdaIn
);
    import tms_pkg::*;
    logic sclQ = 1'b1;
    logic sdaQ = 1'b1;
    // pull-up: a released line reads high, never the last driven value
    assign sdaIn = sdaQ & ~sdaOe;
    // the bus clock stands high between frames
    assign sclIn = sclQ;
    task automatic pin(input logic c, input logic s);
        sclQ <= c;
        sdaQ <= s;
        repeat (2) @(posedge clock);
    endtask
    task automatic start();
        pin(1'b0, 1'b1);
        pin(1'b1, 1'b1);
        pin(1'b1, 1'b0);
        pin(1'b0, 1'b0);
    endtask
    task automatic stop();
        pin(1'b0, 1'b0);
        pin(1'b1, 1'b0);
        pin(1'b1, 1'b1);
    endtask
    // sample late in the high phase, well after the device's answer has settled
    task automatic bitx(input logic b, output logic r);
        sdaQ <= b;
        repeat (2) @(posedge clock);
        sclQ <= 1'b1;
        repeat (4) @(posedge clock);
        r = sdaIn;
        sclQ <= 1'b0;
        repeat (2) @(posedge clock);
    endtask
    task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
                        output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(tx[i], r);
            rx[i] = r;
        end
        bitx(last, r);
        ack = ~r;
    endtask
    task automatic wr(input logic [7:0] ptr, input logic [7:0] d, input logic withData);
        logic [7:0] rx;
        logic a;
        start();
        xfer({DEV_ADDR, 1'b0}, 1'b1, rx, a);
        xfer(ptr, 1'b1, rx, a);
        if (withData) xfer(d, 1'b1, rx, a);
        stop();
    endtask
    // one byte is read, then the host declines more
    task automatic rd(input logic [6:0] addr, output logic [7:0] d, output logic ack);
        logic a;
        start();
        xfer({addr, 1'b1}, 1'b1, d, ack);
        xfer(8'hFF, 1'b1, d, a);
        stop();
    endtask
endmodule // tms_host_model

/* tb/tb.sv */
// self-checking bench for the temperature monitor status logic
`timescale 1ns/1ps
module tb;
    import tms_pkg::*;
    localparam logic [6:0] ADDR = 7'h48;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic rateTick = 1'b0, convDone = 1'b0, remoteOpen = 1'b0;
    logic sclIn, sdaIn, sdaOut, sdaOe, convStart, rangeExt;
    logic overheatOutN, overheatOe, sharedOutN, sharedOe, a;
    tms_temp_t lt = 8'd50, rt = 8'd50, lh = 8'd80, ll = 8'd20, rh = 8'd80, rl = 8'd20;
    tms_temp_t lo = 8'd100, ro = 8'd100, hy = 8'd10;
    logic [7:0] d, v;
    logic [15:0] cases [5] = '{16'h5A32, 16'h0A32, 16'h325A, 16'h320A, 16'h3232};
    tms_temp_t ov [3] = '{8'd105, 8'd95, 8'd90};
    int errors = 0;
    int check_count = 0;
    int cycles = 0;
    int starts = 0;
    int s;
    always #50 clock = ~clock;
    tms_status_top #(.DEV_ADDR(ADDR)) u_tms_status_top (.clock(clock), .nrst(nrst),
        .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .rateTick(rateTick),
        .convDone(convDone), .localTemp(lt), .remoteTemp(rt), .localHighLim(lh),
        .localLowLim(ll), .remoteHighLim(rh), .remoteLowLim(rl), .localOverLim(lo),
        .remoteOverLim(ro), .overHyst(hy), .remoteOpen(remoteOpen), .convStart(convStart),
        .rangeExt(rangeExt), .overheatOutN(overheatOutN), .overheatOe(overheatOe),
        .sharedOutN(sharedOutN), .sharedOe(sharedOe));
    tms_host_model #(.DEV_ADDR(ADDR)) u_tms_host_model (.clock(clock), .sdaOe(sdaOe),
        .sclIn(sclIn), .sdaIn(sdaIn));
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (convStart === 1'b1) starts <= starts + 1;
        if (cycles == 80000) begin
            errors++;
            conclude();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic done(input string n);
        $display("test %s finished, mismatches so far %0d", n, errors);
    endtask
    task automatic rdReg(input logic [7:0] ptr, output logic [7:0] r);
        logic k;
        u_tms_host_model.wr(ptr, 8'h00, 1'b0);
        u_tms_host_model.rd(ADDR, r, k);
    endtask
    task automatic wrCfg(input logic [7:0] c);
        u_tms_host_model.wr(PTR_CFG_WR, c & CFG_WMASK, 1'b1);
    endtask
    task automatic kick(input logic r, input logic c);
        rateTick <= r;
        convDone <= c;
        @(posedge clock);
        rateTick <= 1'b0;
        convDone <= 1'b0;
    endtask
    // one conversion; results are presented together with the done pulse
    task automatic conv(input tms_temp_t l, input tms_temp_t r, input logic busyChk);
        logic [7:0] q;
        s = starts;
        kick(1'b1, 1'b0);
        repeat (3) @(posedge clock);
        chk(8'(starts - s), 8'h01);
        if (busyChk) begin
            rdReg(PTR_STATUS_RD, q);
            chk(q, 8'h80);
        end
        lt <= l;
        rt <= r;
        kick(1'b0, 1'b1);
        // the interrupt-mode shared output lags the done pulse by four edges, overheat by two; look one edge later
        repeat (4) @(posedge clock);
    endtask
    initial begin
        void'($urandom(32'hA00D0EDD));
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        rdReg(PTR_CFG_RD, d);
        chk(d, CFG_RESET);
        chk({3'h0, sdaOut, overheatOe, sharedOe, overheatOutN, sharedOutN}, 8'h03);
        u_tms_host_model.wr(PTR_STATUS_RD, 8'hFF, 1'b1);
        u_tms_host_model.wr(PTR_CFG_RD, 8'h04, 1'b1);
        rdReg(PTR_CFG_RD, d);
        chk(d, CFG_RESET);
        conv(8'd50, 8'd50, 1'b1);
        rdReg(PTR_STATUS_RD, d);
        chk(d, 8'h00);
        rdReg(8'h05, d);
        chk(d, UNMAPPED_DATA);
        u_tms_host_model.rd(ALERT_RESP_ADDR, d, a);
        chk({7'h00, a}, 8'h00);
        done("reset");
        for (int i = 0; i < 4; i++) begin
            v = 8'($urandom) & CFG_WMASK;
            wrCfg(v);
            rdReg(PTR_CFG_RD, d);
            chk(d, v);
            chk({7'h00, rangeExt}, {7'h00, v[CFG_RANGE]});
        end
        wrCfg(8'h00);
        done("config");
        for (int i = 0; i < 5; i++) begin
            remoteOpen <= (i == 4);
            conv(cases[i][15:8], cases[i][7:0], 1'b0);
            chk({7'h00, sharedOutN}, 8'h00);
            rdReg(PTR_STATUS_RD, d);
            rdReg(PTR_STATUS_RD, d);
            chk(d, 8'(8'h40 >> i));
            remoteOpen <= 1'b0;
            conv(8'd50, 8'd50, 1'b0);
            rdReg(PTR_STATUS_RD, d);
            chk(d, 8'(8'h40 >> i));
            rdReg(PTR_STATUS_RD, d);
            chk(d, 8'h00);
            chk({7'h00, sharedOutN}, 8'h00);
            u_tms_host_model.rd(ALERT_RESP_ADDR, d, a);
            chk(d, {ADDR, 1'b0});
            chk({7'h00, a}, 8'h01);
            chk({6'h00, sharedOe, sharedOutN}, 8'h01);
        end
        done("limit flags");
        lh <= 8'd120;
        rh <= 8'd120;
        for (int c = 0; c < 2; c++) begin
            for (int k = 0; k < 3; k++) begin
                conv(c ? 8'd50 : ov[k], c ? ov[k] : 8'd50, 1'b0);
                rdReg(PTR_STATUS_RD, d);
                chk(d, k < 2 ? 8'(c + 1) : 8'h00);
                chk({6'h00, overheatOe, overheatOutN}, k < 2 ? 8'h02 : 8'h01);
            end
        end
        lh <= 8'd80;
        rh <= 8'd80;
        done("overheat");
        wrCfg(8'hA0);
        conv(8'd90, 8'd50, 1'b0);
        chk({7'h00, sharedOutN}, 8'h00);
        conv(8'd10, 8'd50, 1'b0);
        chk({7'h00, sharedOutN}, 8'h01);
        rdReg(PTR_STATUS_RD, d);
        chk(d, 8'h20);
        conv(8'd50, 8'd50, 1'b0);
        wrCfg(8'h80);
        conv(8'd90, 8'd50, 1'b0);
        chk({7'h00, sharedOutN}, 8'h01);
        conv(8'd50, 8'd50, 1'b0);
        rdReg(PTR_STATUS_RD, d);
        chk(d, 8'h40);
        wrCfg(8'h00);
        u_tms_host_model.rd(ALERT_RESP_ADDR, d, a);
        chk({7'h00, sharedOutN}, 8'h01);
        chk({7'h00, a}, 8'h01);
        done("output modes");
        wrCfg(8'h40);
        s = starts;
        kick(1'b1, 1'b0);
        repeat (5) @(posedge clock);
        chk(8'(starts - s), 8'h00);
        u_tms_host_model.wr(PTR_ONESHOT_WR, 8'($urandom), 1'b1);
        repeat (3) @(posedge clock);
        chk(8'(starts - s), 8'h01);
        kick(1'b0, 1'b1);
        kick(1'b1, 1'b0);
        repeat (5) @(posedge clock);
        chk(8'(starts - s), 8'h01);
        rdReg(PTR_ONESHOT_WR, d);
        chk(d, UNMAPPED_DATA);
        wrCfg(8'h00);
        done("shutdown");
        conclude();
    end
endmodule // tb
